// ===== design/dsbt_pkg.sv
// Constants for the serial byte-mode DMA transfer sequencer.
// Assumes a single 25 MHz system clock shared by host, DMA and peripheral bus.
package dsbt_pkg;
	// Clock
	localparam int CLK_HZ = 25_000_000;
	// Widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int TMR_W = 4;
	localparam int FIFO_DEPTH = 4;
	// Inter-event delays in clock periods
	localparam int REQ_DLY_CLK = 2;
	localparam int GRANT_TO_FIRST_CLK = 4;
	localparam int RX_RD_TO_WR_CLK = 4;
	localparam int RX_WR_TO_DROP_CLK = 2;
	localparam int TX_RD_TO_WR_CLK = 3;
	localparam int TX_WR_TO_DROP_CLK = 3;
	localparam int DROP_TO_END_CLK = 1;
	localparam int BUS_OCC_CLK = 13;
	// Cycle marks counted from the grant edge; T_ARM_LAST counts from entry to DSBT_ARM
	localparam logic [TMR_W-1:0] T_FIRST = TMR_W'(GRANT_TO_FIRST_CLK);
	localparam logic [TMR_W-1:0] T_RX_WR = TMR_W'(GRANT_TO_FIRST_CLK + RX_RD_TO_WR_CLK);
	localparam logic [TMR_W-1:0] T_RX_DROP = TMR_W'(GRANT_TO_FIRST_CLK + RX_RD_TO_WR_CLK + RX_WR_TO_DROP_CLK);
	localparam logic [TMR_W-1:0] T_TX_WR = TMR_W'(GRANT_TO_FIRST_CLK + TX_RD_TO_WR_CLK);
	localparam logic [TMR_W-1:0] T_TX_DROP = TMR_W'(GRANT_TO_FIRST_CLK + TX_RD_TO_WR_CLK + TX_WR_TO_DROP_CLK);
	localparam logic [TMR_W-1:0] T_END = TMR_W'(GRANT_TO_FIRST_CLK + RX_RD_TO_WR_CLK + RX_WR_TO_DROP_CLK
		+ DROP_TO_END_CLK);
	localparam logic [TMR_W-1:0] T_ARM_LAST = TMR_W'(REQ_DLY_CLK - 2);
	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	// Sequencer states, Gray from IDLE through RELS; RELS back to IDLE flips two bits
	typedef enum logic [2:0] {
		DSBT_IDLE = 3'b000,
		DSBT_ARM = 3'b001,
		DSBT_WAITG = 3'b011,
		DSBT_XFER = 3'b010,
		DSBT_RELS = 3'b110
	} dsbt_state_t;
endpackage

// ===== design/dsbt_top.sv
// Byte-mode DMA sequencer between a serial peripheral and memory, plus its byte FIFO.
// Assumes the host floats the bus while it grants, and a partner that drains the monitor stream.
module dsbt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [PW:0] cnt_r;
	logic valid_r;
	logic [WIDTH-1:0] head_r;

	// Pointer wrap, shared by both ends
	function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
		wrap_inc = (p == PW'(DEPTH-1)) ? '0 : p + 1'b1;
	endfunction

	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [PW:0] cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
	wire [PW:0] left = cnt_r - (PW+1)'(pop);
	wire [PW-1:0] rp_nxt = pop ? wrap_inc(rp_r) : rp_r;
	// Head kept in a register so the stream leaves from flops
	// Nothing left behind the pop: a pushed word becomes the head
	wire [WIDTH-1:0] head_nxt = (left == '0) ? in_data : mem_r[rp_nxt];
	assign in_ready = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid = valid_r;
	assign out_data = head_r;
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			valid_r <= 1'b0;
			head_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wrap_inc(wp_r);
			end
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			valid_r <= (cnt_nxt != '0);
			head_r <= head_nxt;
		end
	end
endmodule // dsbt_fifo

module dsbt_top
	import dsbt_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Configuration levels
	input wire logic xfer_enable,
	input wire logic rx_mode,
	input wire logic ready_low_sel,
	input wire logic [dsbt_pkg::DATA_W-1:0] io_port,
	input wire logic [dsbt_pkg::ADDR_W-1:0] mem_start,
	input wire logic mem_load,
	// Peripheral and host pins
	input wire logic ready_n,
	input wire logic bus_grant_n,
	input wire logic wait_n,
	output logic bus_request_n,
	// System bus, floated while not master
	output logic [dsbt_pkg::ADDR_W-1:0] addr,
	output logic memory_request_n,
	output logic io_request_n,
	output logic rd_n,
	output logic wr_n,
	output logic ctl_oe_n,
	input wire logic [dsbt_pkg::DATA_W-1:0] data_in,
	output logic [dsbt_pkg::DATA_W-1:0] data_out,
	output logic data_oe_n,
	// Status
	output logic busy,
	// Stream of transferred bytes
	output logic mon_valid,
	input wire logic mon_ready,
	output logic [dsbt_pkg::DATA_W-1:0] mon_data
);
	import dsbt_pkg::*;

	function automatic logic in_win(input logic [TMR_W-1:0] t, input logic [TMR_W-1:0] lo,
		input logic [TMR_W-1:0] hi);
		in_win = (t >= lo) && (t < hi);
	endfunction

	// Pin synchronisers
	logic ready_m;
	logic ready_s;
	logic grant_m;
	logic grant_s;
	logic wait_m;
	logic wait_s;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ready_m <= 1'b1;
			ready_s <= 1'b1;
			grant_m <= 1'b1;
			grant_s <= 1'b1;
			wait_m <= 1'b1;
			wait_s <= 1'b1;
		end else begin
			ready_m <= ready_n;
			ready_s <= ready_m;
			grant_m <= bus_grant_n;
			grant_s <= grant_m;
			wait_m <= wait_n;
			wait_s <= wait_m;
		end
	end

	dsbt_state_t state_r;
	dsbt_state_t state_nxt;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] tmr_nxt;
	logic [ADDR_W-1:0] mem_addr_r;
	logic [DATA_W-1:0] byte_r;
	logic fifo_in_ready;

	// Pin stays as named; polarity chosen by the strap level
	wire rdy_act = ready_low_sel ? ~ready_s : ready_s;
	// Full FIFO holds off the next request, so no byte is dropped
	wire can_start = xfer_enable && rdy_act && fifo_in_ready;
	wire granted = ~grant_s;
	wire in_cycle = in_win(tmr_r, T_FIRST, T_END);
	wire stretch = ~wait_s && in_cycle;
	wire tmr_step = ~stretch;
	wire [TMR_W-1:0] t_rd_end = rx_mode ? T_RX_WR : T_TX_WR;
	wire latch_now = (state_r == DSBT_XFER) && tmr_step && (tmr_r == t_rd_end - 1'b1);
	// Last strobe cycle; bus is freed on the next edge, so grant to end is eleven
	wire xfer_done = (state_r == DSBT_XFER) && tmr_step && (tmr_r == T_END - 1'b1);

	always_comb begin
		state_nxt = state_r;
		tmr_nxt = tmr_r;
		unique case (state_r)
			DSBT_IDLE: begin
				tmr_nxt = '0;
				if (can_start) begin
					state_nxt = DSBT_ARM;
				end
			end
			DSBT_ARM: begin
				if (tmr_r == T_ARM_LAST) begin
					state_nxt = DSBT_WAITG;
				end else begin
					tmr_nxt = tmr_r + 1'b1;
				end
			end
			DSBT_WAITG: begin
				tmr_nxt = '0;
				if (granted) begin
					state_nxt = DSBT_XFER;
				end
			end
			DSBT_XFER: begin
				if (xfer_done) begin
					state_nxt = DSBT_RELS;
				end else if (tmr_step) begin
					tmr_nxt = tmr_r + 1'b1;
				end
			end
			DSBT_RELS: begin
				tmr_nxt = '0;
				// Only one byte per grant; ready is sampled afresh
				if (!granted) begin
					state_nxt = DSBT_IDLE;
				end
			end
			default: begin
				state_nxt = DSBT_IDLE;
				tmr_nxt = '0;
			end
		endcase
	end

	// Bus outputs decoded from the coming cycle count
	wire xfer_nxt = (state_nxt == DSBT_XFER);
	wire req_nxt = (state_nxt == DSBT_WAITG) || (xfer_nxt && (tmr_nxt < (rx_mode ? T_RX_DROP : T_TX_DROP)));
	wire rx_io_rd = xfer_nxt && rx_mode && in_win(tmr_nxt, T_FIRST, T_RX_WR);
	wire rx_mem_wr = xfer_nxt && rx_mode && in_win(tmr_nxt, T_RX_WR, T_END);
	wire tx_mem_rd = xfer_nxt && !rx_mode && in_win(tmr_nxt, T_FIRST, T_TX_WR);
	wire tx_io_wr = xfer_nxt && !rx_mode && in_win(tmr_nxt, T_TX_WR, T_END);
	wire mem_cyc = rx_mem_wr || tx_mem_rd;
	wire io_cyc = rx_io_rd || tx_io_wr;
	wire wr_cyc = rx_mem_wr || tx_io_wr;
	wire [ADDR_W-1:0] addr_nxt = io_cyc ? {{(ADDR_W-DATA_W){1'b0}}, io_port} : mem_addr_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_r <= DSBT_IDLE;
			tmr_r <= '0;
		end else begin
			state_r <= state_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			mem_addr_r <= ADDR_RST;
		end else if (mem_load && state_r == DSBT_IDLE) begin
			mem_addr_r <= mem_start;
		end else if (xfer_done) begin
			mem_addr_r <= mem_addr_r + 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			byte_r <= DATA_RST;
		end else if (latch_now) begin
			byte_r <= data_in;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bus_request_n <= 1'b1;
			addr <= ADDR_RST;
			memory_request_n <= 1'b1;
			io_request_n <= 1'b1;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			ctl_oe_n <= 1'b1;
			data_oe_n <= 1'b1;
			data_out <= DATA_RST;
			busy <= 1'b0;
		end else begin
			bus_request_n <= ~req_nxt;
			addr <= addr_nxt;
			memory_request_n <= ~mem_cyc;
			io_request_n <= ~io_cyc;
			rd_n <= ~(rx_io_rd || tx_mem_rd);
			wr_n <= ~wr_cyc;
			ctl_oe_n <= ~xfer_nxt;
			data_oe_n <= ~wr_cyc;
			data_out <= latch_now ? data_in : byte_r;
			busy <= (state_nxt != DSBT_IDLE);
		end
	end

	// Every moved byte also leaves on the stream
	dsbt_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.in_valid(latch_now),
		.in_ready(fifo_in_ready),
		.in_data(data_in),
		.out_valid(mon_valid),
		.out_ready(mon_ready),
		.out_data(mon_data)
	);
endmodule // dsbt_top

// ===== verif/dsbt_host.sv
// Host and memory model: grants after a set delay, returns a byte on reads.
// Assumes one requester on a same-clock bus.
module dsbt_host (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Bench settings
	input wire logic [3:0] lat,
	input wire logic [7:0] rd_byte,
	// Bus
	input wire logic bus_request_n,
	input wire logic ctl_oe_n,
	input wire logic rd_n,
	output logic bus_grant_n,
	output logic [7:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt_r;
	// Idle bus shows the inverse, never a stale byte
	assign data_in = rd_n ? ~rd_byte : rd_byte;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			bus_grant_n <= 1'b1;
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= (bus_grant_n && !bus_request_n) ? cnt_r + 4'h1 : 4'h0;
			if (bus_grant_n && !bus_request_n && cnt_r == lat) bus_grant_n <= 1'b0;
			if ($rose(ctl_oe_n)) bus_grant_n <= 1'b1;
		end
	end
endmodule // dsbt_host

// ===== verif/dsbt_top_props.sv
// Checker for dsbt_top strobe order and handshake.
// Assumes wait_n stays high outside the stretch test.
module dsbt_top_props (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Inputs
	input wire logic xfer_enable,
	input wire logic rx_mode,
	input wire logic ready_low_sel,
	input wire logic ready_n,
	input wire logic wait_n,
	// Outputs
	input wire logic bus_request_n,
	input wire logic memory_request_n,
	input wire logic io_request_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic ctl_oe_n,
	input wire logic data_oe_n,
	input wire logic busy,
	input wire logic mon_valid
);
	// Wait stretches timing, so it cancels attempts
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn || !wait_n);
	property p_req;
		$fell(ready_n) && ready_low_sel && xfer_enable && !busy && !mon_valid |-> ##[3:6] !bus_request_n;
	endproperty
	a_req: assert property (p_req) else $error("late request");
	property p_rx;
		rx_mode && $fell(io_request_n) |-> (!io_request_n && !rd_n)[*4] ##1 (io_request_n && !memory_request_n && !wr_n);
	endproperty
	a_rx: assert property (p_rx) else $error("bad rx order");
	property p_rxe;
		rx_mode && $fell(memory_request_n) |-> ##2 (bus_request_n && !wr_n) ##1 (wr_n && data_oe_n);
	endproperty
	a_rxe: assert property (p_rxe) else $error("bad rx end");
	property p_tx;
		!rx_mode && $fell(memory_request_n) |-> (!memory_request_n && !rd_n)[*3] ##1 (!io_request_n && !wr_n);
	endproperty
	a_tx: assert property (p_tx) else $error("bad tx order");
	property p_txe;
		!rx_mode && $fell(io_request_n) |-> ##3 (bus_request_n && !wr_n) ##1 wr_n;
	endproperty
	a_txe: assert property (p_txe) else $error("bad tx end");
	property p_occ;
		$fell(ctl_oe_n) |-> !ctl_oe_n[*8] ##1 !ctl_oe_n[*3] ##1 ctl_oe_n;
	endproperty
	a_occ: assert property (p_occ) else $error("bad bus hold");
	property p_end;
		$rose(ctl_oe_n) |-> bus_request_n && memory_request_n && io_request_n && rd_n && wr_n && data_oe_n;
	endproperty
	a_end: assert property (p_end) else $error("bus not freed");
	property p_wt;
		disable iff (!rstn) !wait_n && !$past(wait_n) && !$past(wait_n, 2) && !io_request_n |=> !io_request_n;
	endproperty
	a_wt: assert property (p_wt) else $error("wait ignored");
endmodule // dsbt_top_props
bind dsbt_top dsbt_top_props i_dsbt_top_props (.*);

// ===== verif/test_dma_serial_byte_transfer.sv
// Bench for the byte-mode DMA sequencer with a host model.
// Assumes fixed strobe timing and a 4-deep monitor FIFO.
module test_dma_serial_byte_transfer;
	import dsbt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic rx; logic [7:0] b; logic [3:0] l;} dsbt_row_t;
	logic ref_clk, rstn, xfer_enable, rx_mode, ready_low_sel, mem_load, ready_n, bus_grant_n, wait_n;
	logic bus_request_n, memory_request_n, io_request_n, rd_n, wr_n, ctl_oe_n, data_oe_n, busy, mon_valid, mon_ready;
	logic [7:0] data_in, data_out, mon_data, rd_byte;
	logic [15:0] addr;
	logic [3:0] lat;
	int num_errors, checks_done, cyc, n;
	dsbt_row_t rows [4] = '{'{1'b1, 8'ha5, 4'h1}, '{1'b0, 8'h3c, 4'h5}, '{1'b1, 8'hff, 4'h3}, '{1'b0, 8'h00, 4'h2}};
	dsbt_top i_dsbt_top (.*, .io_port(8'h5a), .mem_start(16'h1000));
	dsbt_host i_dsbt_host (.*);
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task tally_and_finish;
		$display("Errors %0d, checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// Ready is held until the write shows, then dropped
	task xfer(input dsbt_row_t r, input logic [15:0] ma);
		@(negedge ref_clk);
		rx_mode = r.rx;
		rd_byte = r.b;
		lat = r.l;
		ready_n = !ready_low_sel;
		@(negedge ref_clk iff !wr_n);
		ready_n = ready_low_sel;
		chk(data_out, r.b);
		chk(addr, r.rx ? ma : 16'h005a);
		@(negedge ref_clk iff !busy);
	endtask
	task pop(input logic [7:0] b);
		@(negedge ref_clk iff mon_valid);
		chk(mon_data, b);
		mon_ready = 1'b1;
		@(negedge ref_clk);
		mon_ready = 1'b0;
	endtask
	initial begin
		rstn = 1'b0;
		xfer_enable = 1'b1;
		rx_mode = 1'b1;
		ready_low_sel = 1'b1;
		mem_load = 1'b1;
		ready_n = 1'b1;
		wait_n = 1'b1;
		mon_ready = 1'b0;
		rd_byte = 8'h00;
		lat = 4'h1;
		repeat (5) @(negedge ref_clk);
		chk(bus_request_n & ctl_oe_n & ~busy, 1'b1);
		chk(addr, 16'h0000);
		rstn = 1'b1;
		@(negedge ref_clk);
		mem_load = 1'b0;
		foreach (rows[i]) begin
			xfer(rows[i], 16'h1000 + 16'(i));
			pop(rows[i].b);
		end
		// Full FIFO must hold off the next request
		foreach (rows[i]) xfer(rows[i], 16'h1004 + 16'(i));
		ready_n = 1'b0;
		repeat (12) @(negedge ref_clk);
		chk(bus_request_n, 1'b1);
		ready_n = 1'b1;
		foreach (rows[i]) pop(rows[i].b);
		xfer_enable = 1'b0;
		ready_n = 1'b0;
		repeat (12) @(negedge ref_clk);
		chk(bus_request_n, 1'b1);
		xfer_enable = 1'b1;
		ready_low_sel = 1'b0;
		repeat (12) @(negedge ref_clk);
		chk(bus_request_n, 1'b1);
		xfer(rows[1], 16'h0000);
		pop(rows[1].b);
		ready_low_sel = 1'b1;
		rx_mode = 1'b1;
		rd_byte = 8'h96;
		ready_n = 1'b0;
		@(negedge ref_clk iff !io_request_n);
		wait_n = 1'b0;
		n = 0;
		while (io_request_n === 1'b0) begin
			@(negedge ref_clk);
			n++;
			if (n == 3) wait_n = 1'b1;
		end
		chk(16'(n), 16'h0007);
		ready_n = 1'b1;
		@(negedge ref_clk iff !busy);
		pop(8'h96);
		tally_and_finish();
	end
endmodule // test_dma_serial_byte_transfer
